// file: common/ssp_pkg.sv
// Package for the sync serial port SPI core: offsets, fields, types
package ssp_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_DATA_BUF    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h10;
  // Control one fields
  localparam int CTL_WRITE_COLLISION_FLAG_BIT  = 7;
  localparam int CTL_OVF_BIT   = 6;
  localparam int CTL_EN_BIT    = 5;
  localparam int CTL_CKP_BIT   = 4;
  // Status fields
  localparam int STA_SMP_BIT   = 7;
  localparam int STA_CKE_BIT   = 6;
  localparam int STA_BF_BIT    = 0;
  // Interrupt status fields
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG_BIT  = 1;
  localparam int IRQ_OVF_BIT   = 2;
  // Reset values
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [1:0] STATUS_CFG_RST  = 2'h0;
  localparam logic [2:0] IRQ_MASK_RST    = 3'h0;
  // Mode select codes
  localparam logic [3:0] MODE_MST_DIV4   = 4'h0;
  localparam logic [3:0] MODE_MST_DIV16  = 4'h1;
  localparam logic [3:0] MODE_MST_DIV64  = 4'h2;
  localparam logic [3:0] MODE_MST_TMR    = 4'h3;
  localparam logic [3:0] MODE_SLV_SS     = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS   = 4'h5;
  // Half periods of serial clock in system cycles
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] WORD_BITS  = 4'h8;
  // Serial pin bundles
  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
  } ssp_pins_out_s;
  typedef struct packed {
    logic sck_i;
    logic sdi_i;
    logic ss_n_i;
  } ssp_pins_in_s;
endpackage : ssp_pkg

// file: rtl/ssp_sync.sv
// Two-stage synchroniser for serial pin inputs
`timescale 1ns/10ps
module ssp_sync (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [2:0] d,
  output logic      [2:0] q
);
  logic [2:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 3'h7;
      q        <= 3'h7;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ssp_sync

// file: rtl/ssp_core.sv
// SPI mode of the sync serial port, AHB-Lite slave with interrupt
`timescale 1ns/10ps
// Overview of operation
// - Each transfer moves one 8-bit word out and in at once.
// - Clock polarity and transmit edge select all four SPI modes.
// - Normal operation uses data out, data in and serial clock.
// - Slave may be selected by an active-low select input.
// - Control one is fully readable and writable.
// - Status low six bits are read-only; writes ignored.
// - Status top two bits hold writable configuration.
// - Shift register reached only through the data buffer.
// - A full word moves to the buffer, unless a slave buffer is still full, and sets the interrupt flag.
// - Receive is double buffered; next word shifts while buffer holds.
// - Buffer write loads both buffer and shift register.
// - Data shifts most significant bit first.
// - Buffer write during a transfer is dropped and sets collision flag.
// - Buffer full sets on receive, clears on buffer read.
// - Mode field selects master dividers, timer clock, or slave modes.
module ssp_core (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  timer_tick,
  input  ssp_pkg::ssp_pins_in_s      pins_in,
  output ssp_pkg::ssp_pins_out_s     pins_out,
  output logic                       irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} ssp_state_e;

  logic [7:0]  control_one_reg;
  logic [1:0]  status_cfg_reg;
  logic        rx_buffer_full_reg;
  logic [7:0]  serial_data_buffer_reg;
  logic [7:0]  serial_shift_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_mask_reg;
  ssp_state_e  state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [5:0]  div_cnt_reg;
  logic        sck_reg;
  logic        sdo_reg;
  logic        sck_prev_reg;
  logic [2:0]  pin_sync;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;

  // Pins come from another domain, two flops first
  ssp_sync u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({pins_in.sck_i, pins_in.sdi_i, pins_in.ss_n_i}),
    .q       (pin_sync)
  );

  logic s_sck, s_sdi, s_ss_n;
  assign s_sck  = pin_sync[2];
  assign s_sdi  = pin_sync[1];
  assign s_ss_n = pin_sync[0];

  logic [3:0] mode;
  logic       enabled, master, ckp, cke, busy;
  assign mode    = control_one_reg[3:0];
  assign enabled = control_one_reg[ssp_pkg::CTL_EN_BIT];
  assign ckp     = control_one_reg[ssp_pkg::CTL_CKP_BIT];
  assign cke     = status_cfg_reg[0];
  assign master  = (mode <= ssp_pkg::MODE_MST_TMR);
  // Slave is busy once the first bit of a word is in
  assign busy    = master ? (state_reg != ST_IDLE) : (bit_cnt_reg != 4'h0);

  // Half period count for the chosen master clock
  function automatic logic [5:0] half_period(input logic [3:0] m);
    if (m == ssp_pkg::MODE_MST_DIV16) half_period = ssp_pkg::HALF_DIV16;
    else if (m == ssp_pkg::MODE_MST_DIV64) half_period = ssp_pkg::HALF_DIV64;
    else half_period = ssp_pkg::HALF_DIV4;
  endfunction : half_period

  // Bus address phase capture; zero wait states
  logic addr_ok;
  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      if (addr_ok) addr_reg <= haddr;
    end
  end

  logic wr_ctl, wr_sta, wr_buf, wr_msk, rd_buf, rd_irq;
  assign wr_ctl = wr_pend_reg && addr_reg == ssp_pkg::OFS_CONTROL_ONE;
  assign wr_sta = wr_pend_reg && addr_reg == ssp_pkg::OFS_STATUS;
  assign wr_buf = wr_pend_reg && addr_reg == ssp_pkg::OFS_DATA_BUF;
  assign wr_msk = wr_pend_reg && addr_reg == ssp_pkg::OFS_IRQ_MASK;
  assign rd_buf = addr_ok && !hwrite && haddr == ssp_pkg::OFS_DATA_BUF;
  assign rd_irq = addr_ok && !hwrite && haddr == ssp_pkg::OFS_IRQ_STATUS;

  // Slave edge detect on synchronised clock, mode from polarity
  logic slv_sel, sck_lead, sck_trail;
  assign slv_sel   = enabled && !master &&
                     (mode == ssp_pkg::MODE_SLV_NOSS || !s_ss_n);
  assign sck_lead  = (s_sck != sck_prev_reg) && (s_sck != ckp);
  assign sck_trail = (s_sck != sck_prev_reg) && (s_sck == ckp);

  // Transfer start on an idle buffer write
  logic start_ok, collide, word_done;
  assign start_ok = wr_buf && !busy;
  assign collide  = wr_buf && busy;

  // Master clock divider tick
  logic m_tick;
  assign m_tick = (mode == ssp_pkg::MODE_MST_TMR) ? timer_tick
                : (div_cnt_reg == 6'h01);

  // Sample strobe and transmit (data out) strobe for both roles
  logic sample_ev, shift_ev;
  always_comb begin
    sample_ev = 1'b0;
    shift_ev  = 1'b0;
    if (master) begin
      // Master samples at the trailing edge: two sync flops make the value
      // read there the one from mid bit; needs half period of 3 with cke=0
      if (m_tick && state_reg == ST_TRAIL) begin
        sample_ev = 1'b1;
        shift_ev  = cke;
      end
      if (m_tick && state_reg == ST_LEAD)
        shift_ev = !cke && (bit_cnt_reg != 4'h0);
    end else if (slv_sel) begin
      sample_ev = cke ? sck_lead : sck_trail;
      shift_ev  = cke ? sck_trail : (sck_lead && bit_cnt_reg != 4'h0);
    end
  end

  // Sample point is fixed; the sample-phase bit is stored only
  logic din;
  assign din = s_sdi;
  assign word_done = sample_ev && (bit_cnt_reg == ssp_pkg::WORD_BITS - 4'h1);

  // Master clock state machine; slave stays idle and follows the pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      div_cnt_reg <= ssp_pkg::HALF_DIV4;
      sck_reg     <= 1'b0;
    end else if (!enabled || !master) begin
      state_reg   <= ST_IDLE;
      div_cnt_reg <= half_period(mode);
      sck_reg     <= ckp;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sck_reg     <= ckp;
          div_cnt_reg <= half_period(mode);
          if (start_ok) state_reg <= ST_LEAD;
        end
        ST_LEAD: begin
          div_cnt_reg <= m_tick ? half_period(mode) : div_cnt_reg - 6'h01;
          if (m_tick) begin
            sck_reg   <= !ckp;
            state_reg <= ST_TRAIL;
          end
        end
        default: begin
          div_cnt_reg <= m_tick ? half_period(mode) : div_cnt_reg - 6'h01;
          if (m_tick) begin
            sck_reg   <= ckp;
            state_reg <= word_done ? ST_IDLE : ST_LEAD;
          end
        end
      endcase
    end
  end

  // Bit counter counts sampled bits; a deselect drops a cut word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) bit_cnt_reg <= 4'h0;
    else if (!enabled || (!master && !slv_sel)) bit_cnt_reg <= 4'h0;
    else if (sample_ev) bit_cnt_reg <= word_done ? 4'h0 : bit_cnt_reg + 4'h1;
  end

  // Shift register, MSB first; shifts on sample, output on transmit edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_shift_reg <= 8'h00;
      sdo_reg          <= 1'b0;
    end else if (start_ok) begin
      serial_shift_reg <= hwdata[7:0];
      sdo_reg          <= hwdata[7];
    end else begin
      if (sample_ev) serial_shift_reg <= {serial_shift_reg[6:0], din};
      // A shift in the same cycle moves the next bit down one place
      if (shift_ev) sdo_reg <= sample_ev ? serial_shift_reg[6] : serial_shift_reg[7];
    end
  end

  // Buffer: loads from write, or from shift register at word end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_data_buffer_reg <= 8'h00;
    end else if (start_ok) begin
      serial_data_buffer_reg <= hwdata[7:0];
    end else if (word_done && !(rx_buffer_full_reg && !master)) begin
      // Slave overflow drops the new word, old one is kept
      serial_data_buffer_reg <= {serial_shift_reg[6:0], din};
    end
  end

  // Buffer full: set wins over a read in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rx_buffer_full_reg <= 1'b0;
    else if (word_done) rx_buffer_full_reg <= 1'b1;
    else if (rd_buf) rx_buffer_full_reg <= 1'b0;
  end

  // Control one: full software access, hardware sets flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      control_one_reg <= ssp_pkg::CONTROL_ONE_RST;
    end else begin
      if (wr_ctl) control_one_reg <= hwdata[7:0];
      if (collide) control_one_reg[ssp_pkg::CTL_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
      if (word_done && rx_buffer_full_reg && !master)
        control_one_reg[ssp_pkg::CTL_OVF_BIT] <= 1'b1;
    end
  end

  // Status upper bits writable, lower six from hardware only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) status_cfg_reg <= ssp_pkg::STATUS_CFG_RST;
    else if (wr_sta) status_cfg_reg <= hwdata[7:6];
  end

  // Interrupt sticky bits; an event beats the read clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg   <= ssp_pkg::IRQ_MASK_RST;
    end else begin
      irq_status_reg <= (rd_irq ? 3'h0 : irq_status_reg) |
        {word_done && rx_buffer_full_reg && !master, collide, word_done};
      if (wr_msk) irq_mask_reg <= hwdata[2:0];
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read data registered at the address phase; shift reg not mapped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      if (haddr == ssp_pkg::OFS_CONTROL_ONE) hrdata <= {24'h0, control_one_reg};
      else if (haddr == ssp_pkg::OFS_STATUS)
        hrdata <= {24'h0, status_cfg_reg, 5'h00, rx_buffer_full_reg};
      else if (haddr == ssp_pkg::OFS_DATA_BUF)
        hrdata <= {24'h0, serial_data_buffer_reg};
      else if (haddr == ssp_pkg::OFS_IRQ_STATUS) hrdata <= {29'h0, irq_status_reg};
      else if (haddr == ssp_pkg::OFS_IRQ_MASK) hrdata <= {29'h0, irq_mask_reg};
      else hrdata <= 32'h0;
    end
  end

  // Previous clock for slave edges, from second sync stage only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) sck_prev_reg <= 1'b1;  // Matches sync reset, no false edge
    else sck_prev_reg <= s_sck;
  end

  // Pins: master drives clock; slave drives data only when selected
  always_comb begin
    pins_out.sck_o    = sck_reg;
    pins_out.sck_oe_n = !(enabled && master);
    pins_out.sdo_o    = sdo_reg;
    pins_out.sdo_oe_n = !(enabled && (master || slv_sel));
  end

  // Assertions
  a_write_collision_flag_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    collide |=> control_one_reg[ssp_pkg::CTL_WRITE_COLLISION_FLAG_BIT])
    else $error("collision flag not set");
  a_bf_on_done: assert property (@(posedge clk_sys) disable iff (!rstn)
    word_done |=> rx_buffer_full_reg)
    else $error("buffer full not set");
  a_irq_done: assert property (@(posedge clk_sys) disable iff (!rstn)
    word_done |=> irq_status_reg[ssp_pkg::IRQ_DONE_BIT])
    else $error("done flag not set");
  a_load_both: assert property (@(posedge clk_sys) disable iff (!rstn)
    start_ok |=> serial_shift_reg == serial_data_buffer_reg)
    else $error("buffer and shifter differ");
  a_start_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
    start_ok && enabled && master |=> busy)
    else $error("transfer not started");
  a_sta_lowro: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_sta |=> $stable(rx_buffer_full_reg) || word_done || $past(rd_buf))
    else $error("status low bits written");
  a_ctl_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ctl && !collide && !word_done |=> control_one_reg == $past(hwdata[7:0]))
    else $error("control write lost");
  a_sta_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_sta |=> status_cfg_reg == $past(hwdata[7:6]))
    else $error("status cfg write lost");
  a_eight_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
    busy |-> bit_cnt_reg < ssp_pkg::WORD_BITS)
    else $error("bit count past word");
  c_master_word: cover property (@(posedge clk_sys) disable iff (!rstn)
    master && word_done);
  c_slave_word: cover property (@(posedge clk_sys) disable iff (!rstn)
    !master && word_done);
  c_collision: cover property (@(posedge clk_sys) disable iff (!rstn) collide);
endmodule : ssp_core

// file: verif/ssp_spi_peer.sv
// Behavioural SPI peripheral that faces the core in master operation
`timescale 1ns/10ps
module ssp_spi_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cke,
  input  wire logic       arm,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte,
  output int              n_edges,
  output realtime         t0,
  output realtime         t1
);
  logic [7:0] tx_reg;
  int         n_tx;
  // Disarmed line shows the inverse so a stale bit is never mistaken for data
  assign miso = arm ? tx_reg[7] : ~tx_reg[7];
  // Preload the reply so its top bit is ready before the first edge
  initial tx_reg = 8'h00;
  always @(posedge arm) begin
    tx_reg = tx_byte;
    n_tx = 0;
    n_edges = 0;
    rx_byte = 8'h00;
  end
  // Sample on one edge, shift on the other, as polarity and edge select say
  always @(sck) begin
    if (arm) begin
      n_edges++;
      if (n_edges == 1) t0 = $realtime;
      if (n_edges == 2) t1 = $realtime;
      if ((sck !== cpol) == cke) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else begin
        if (cke || n_tx > 0) tx_reg = {tx_reg[6:0], 1'b0};
        n_tx++;
      end
    end
  end
endmodule : ssp_spi_peer

// file: verif/tb.sv
// Self-checking bench for the SPI core: registers, master, slave, interrupt
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] TICK_GAP = 32'd3;
  logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp, timer_tick, irq;
  logic [7:0] haddr;
  logic [1:0] htrans, tick_cnt;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic tb_sck, tb_sdi, tb_ss_n, slv, cpol, cke, peer_arm, peer_miso, sck_w, sdo_w;
  logic [7:0] peer_tx, peer_rx;
  int n_edges, err_total, n_checks;
  realtime t0, t1;
  ssp_pkg::ssp_pins_in_s pins_in_w;
  ssp_pkg::ssp_pins_out_s pins_out_w;
  // Wire levels from both parties' enables; released data out floats high
  assign sck_w = pins_out_w.sck_oe_n ? tb_sck : pins_out_w.sck_o;
  assign sdo_w = pins_out_w.sdo_oe_n ? 1'b1 : pins_out_w.sdo_o;
  assign pins_in_w.sck_i = sck_w;
  assign pins_in_w.sdi_i = slv ? tb_sdi : peer_miso;
  assign pins_in_w.ss_n_i = tb_ss_n;
  ssp_core uut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_tick(timer_tick), .pins_in(pins_in_w), .pins_out(pins_out_w), .irq(irq));
  ssp_spi_peer peer (.sck(sck_w), .mosi(sdo_w), .cpol(cpol), .cke(cke), .arm(peer_arm),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx), .n_edges(n_edges),
    .t0(t0), .t1(t1));
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Timer pulse every third cycle feeds the timer-clocked master mode
  always @(posedge clk_sys) begin
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    timer_tick <= (tick_cnt == 2'h2);
  end
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp=%h got=%h", nm, exp, got);
    end
  endtask : chk
  // Bounded wait for hready; a stuck bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
  endtask : wait_rdy
  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    n = 0;
    while (irq !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      give_verdict();
    end
  endtask : wait_irq
  // One single AHB-Lite word transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(a, 1'b0, 32'h0, d);
    chk(nm, d, exp);
  endtask : rdc
  task automatic t_regs();
    rdc("ctl_rst", ssp_pkg::OFS_CONTROL_ONE, 32'h0);
    rdc("sta_rst", ssp_pkg::OFS_STATUS, 32'h0);
    rdc("msk_rst", ssp_pkg::OFS_IRQ_MASK, 32'h0);
    wr(ssp_pkg::OFS_CONTROL_ONE, 32'h94);
    rdc("ctl_rw", ssp_pkg::OFS_CONTROL_ONE, 32'h94);
    wr(ssp_pkg::OFS_CONTROL_ONE, 32'h0);
    wr(ssp_pkg::OFS_STATUS, 32'hff);
    rdc("sta_rw", ssp_pkg::OFS_STATUS, 32'hc0);
    wr(8'h14, 32'hff);
    rdc("unmapped", ssp_pkg::OFS_CONTROL_ONE, 32'h0);
    chk("okay", {31'h0, hresp}, 32'h0);
  endtask : t_regs
  // Master transfer; mode index also walks all four clock polarity/edge pairs
  task automatic t_master(input logic [1:0] m);
    logic [7:0] tx;
    logic [7:0] pk;
    logic [31:0] hp;
    tx = 8'hc3 ^ {m, m, m, m};
    pk = 8'h5a ^ {m, 2'h0, m, 2'h0};
    hp = (m == 2'h0) ? 32'(ssp_pkg::HALF_DIV4) : (m == 2'h1) ? 32'(ssp_pkg::HALF_DIV16)
       : (m == 2'h2) ? 32'(ssp_pkg::HALF_DIV64) : TICK_GAP;
    cpol = m[0];
    cke = ~m[1];  // Divide-by-4 runs with cke set; cke clear needs half period 3
    wr(ssp_pkg::OFS_CONTROL_ONE, {24'h0, 2'h0, 1'b1, cpol, 2'h0, m});
    wr(ssp_pkg::OFS_STATUS, {24'h0, 1'b0, cke, 6'h0});
    peer_tx = pk;
    peer_arm <= 1'b1;
    wr(ssp_pkg::OFS_DATA_BUF, {24'h0, tx});
    if (m == 2'h0) begin
      wr(ssp_pkg::OFS_DATA_BUF, 32'hff);
      rdc("collide", ssp_pkg::OFS_CONTROL_ONE, 32'ha0);
    end
    wait_irq(1'b1, 1200);
    chk("peer_rx", {24'h0, peer_rx}, {24'h0, tx});
    chk("edges", 32'(n_edges), 32'd16);
    chk("half", 32'(int'((t1 - t0) / 10.0)), hp);
    rdc("bf_set", ssp_pkg::OFS_STATUS, {24'h0, 1'b0, cke, 6'h1});
    rdc("rxbuf", ssp_pkg::OFS_DATA_BUF, {24'h0, pk});
    rdc("bf_clr", ssp_pkg::OFS_STATUS, {24'h0, 1'b0, cke, 6'h0});
    rdc("irq_st", ssp_pkg::OFS_IRQ_STATUS, (m == 2'h0) ? 32'h3 : 32'h1);
    @(posedge clk_sys);
    chk("irq_low", {31'h0, irq}, 32'h0);
    peer_arm <= 1'b0;
  endtask : t_master
  // Bench acts as external master; select goes low around each frame
  task automatic slv_frame(input logic [7:0] mo, output logic [7:0] mi);
    tb_ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tb_sdi <= mo[i];
      repeat (10) @(posedge clk_sys);
      tb_sck <= 1'b1;
      mi[i] = sdo_w;
      repeat (10) @(posedge clk_sys);
      tb_sck <= 1'b0;
    end
    repeat (10) @(posedge clk_sys);
    tb_ss_n <= 1'b1;
    tb_sdi <= ~tb_sdi;
    repeat (10) @(posedge clk_sys);
  endtask : slv_frame
  task automatic t_slave();
    logic [7:0] mi;
    logic [31:0] d;
    slv = 1'b1;
    wr(ssp_pkg::OFS_CONTROL_ONE, 32'h24);
    wr(ssp_pkg::OFS_STATUS, 32'h40);
    wr(ssp_pkg::OFS_IRQ_MASK, 32'h0);
    wr(ssp_pkg::OFS_DATA_BUF, 32'h3c);
    slv_frame(8'hc5, mi);
    chk("slv_tx", {24'h0, mi}, 32'h3c);
    rdc("slv_bf", ssp_pkg::OFS_STATUS, 32'h41);
    slv_frame(8'h11, mi);
    rdc("ovf", ssp_pkg::OFS_CONTROL_ONE, 32'h64);
    rdc("slv_rx", ssp_pkg::OFS_DATA_BUF, 32'hc5);
    chk("masked", {31'h0, irq}, 32'h0);
    wr(ssp_pkg::OFS_IRQ_MASK, 32'h4);
    wait_irq(1'b1, 10);
    bus(ssp_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0, d);
    chk("irq_ovf", d & 32'h4, 32'h4);
    wait_irq(1'b0, 10);
  endtask : t_slave
  // Main sequence: reset, then each scenario in turn
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, timer_tick, tick_cnt} = '0;
    hsize = 3'h2;
    {tb_sck, tb_sdi, slv, cpol, cke, peer_arm, err_total, n_checks} = '0;
    tb_ss_n = 1'b1;
    peer_tx = 8'h00;
    rstn = 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    wr(ssp_pkg::OFS_IRQ_MASK, 32'h1);
    for (int m = 0; m < 4; m++) t_master(2'(m));
    t_slave();
    give_verdict();
  end
endmodule : tb
